// File: logic/gx_top.sv
`timescale 1ns/1ps
// Function
// - alert when pin differs from input register
// - alert is open-drain active low
// - all interrupt masks set at power-up
// - three straps give low address bits
// - all pins inputs after reset
// - latched change held until input read
// - masked pin never raises the alert
// - read-only status shows alert source pins
// - one bit picks push-pull or open-drain
// - two-bit drive strength per pin
// - per-pin pull enable and pull direction
// - bus clock up to 400 kHz
// - input, output, polarity, configuration registers
// - address bit zero high means read
// - first written byte loads register pointer
// - configuration one is input, zero output
// - polarity one inverts sensed pin level
module gx_top import gx_pkg::*; (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	// serial bus
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// address straps
	input  wire logic        addr_strap_0,
	input  wire logic        addr_strap_1,
	input  wire logic        addr_strap_2,
	// port pins
	input  wire logic [7:0]  port_pin_i,
	output logic      [7:0]  port_pin_o,
	output logic      [7:0]  port_pin_oe,
	// pad controls
	output logic      [15:0] drive_str_o,
	output logic      [7:0]  pull_en_o,
	output logic      [7:0]  pull_up_o,
	// change alert
	input  wire logic        alert_n_i,
	output logic             alert_n_o,
	output logic             alert_n_oe
);
	logic [1:0] bus_s;
	logic [2:0] strap_s;
	logic [3:0] cnt_q;
	gx_st_t     st_q;
	logic [7:0] pin_s, sh_q, ptr_q, rd_byte;
	logic [7:0] out_q, pol_q, cfg_q, ds0_q, ds1_q, lat_q;
	logic [7:0] pen_q, psel_q, mask_q, opc_q, snap_q, hold_q, held_q;
	logic       scl_q, sda_q, addr_ph_q, cmd_got_q, rw_q, nack_q;
	logic       sda_oe_q, alert_q, fresh_q;
	gx_port_if  pif ();

	// sync depth stays well inside the shortest scl half period
	gx_sync #(.W(2), .RST(2'h3)) u_bus_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.ce       (ce),
		.d        ({scl_i, sda_i}),
		.q        (bus_s)
	);

	gx_sync #(.W(8), .RST(BYTE_ZERO)) u_pin_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.ce       (ce),
		.d        (port_pin_i),
		.q        (pin_s)
	);

	gx_sync #(.W(3), .RST(3'h0)) u_strap_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.ce       (ce),
		.d        ({addr_strap_2, addr_strap_1, addr_strap_0}),
		.q        (strap_s)
	);

	gx_port u_port (
		.core_clk (core_clk),
		.resetn   (resetn),
		.p        (pif.drv)
	);

	// bus conditions
	wire scl_s     = bus_s[1];
	wire sda_s     = bus_s[0];
	wire scl_rise  = scl_s & ~scl_q;
	wire scl_fall  = ~scl_s & scl_q;
	wire start_c   = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_c    = scl_s & scl_q & ~sda_q & sda_s;
	wire byte_end  = (st_q == ST_RX) & scl_fall & (cnt_q == BYTE_BITS);
	wire addr_hit  = sh_q[7:1] == {ADDR_BASE, strap_s};
	wire addr_done = byte_end & addr_ph_q;
	wire cmd_done  = byte_end & ~addr_ph_q & ~cmd_got_q;
	wire wr_fire   = byte_end & ~addr_ph_q & cmd_got_q;
	wire rd_load   = scl_fall & (((st_q == ST_ACK) & rw_q) | ((st_q == ST_RACK) & ~nack_q));
	wire in_read   = rd_load & (ptr_q == REG_IN);

	// register write strobes
	wire wr_out  = wr_fire & (ptr_q == REG_OUT);
	wire wr_pol  = wr_fire & (ptr_q == REG_POL);
	wire wr_cfg  = wr_fire & (ptr_q == REG_CFG);
	wire wr_ds0  = wr_fire & (ptr_q == REG_DS0);
	wire wr_ds1  = wr_fire & (ptr_q == REG_DS1);
	wire wr_lat  = wr_fire & (ptr_q == REG_LAT);
	wire wr_pen  = wr_fire & (ptr_q == REG_PEN);
	wire wr_psel = wr_fire & (ptr_q == REG_PSEL);
	wire wr_mask = wr_fire & (ptr_q == REG_MASK);
	wire wr_opc  = wr_fire & (ptr_q == REG_OPC);

	// input sensing and change tracking
	wire [7:0] sensed  = pin_s ^ pol_q;
	wire [7:0] differ  = sensed ^ snap_q;
	wire [7:0] lat_hit = lat_q & hold_q;
	wire [7:0] capture = lat_q & ~hold_q & differ;
	wire [7:0] pend    = lat_hit | (~lat_q & differ);
	wire [7:0] ist     = pend & ~mask_q;
	wire [7:0] in_view = (lat_hit & held_q) | (~lat_hit & sensed);

	// read data select
	assign rd_byte = (ptr_q == REG_IN)   ? in_view :
	                 (ptr_q == REG_OUT)  ? out_q   :
	                 (ptr_q == REG_POL)  ? pol_q   :
	                 (ptr_q == REG_CFG)  ? cfg_q   :
	                 (ptr_q == REG_DS0)  ? ds0_q   :
	                 (ptr_q == REG_DS1)  ? ds1_q   :
	                 (ptr_q == REG_LAT)  ? lat_q   :
	                 (ptr_q == REG_PEN)  ? pen_q   :
	                 (ptr_q == REG_PSEL) ? psel_q  :
	                 (ptr_q == REG_MASK) ? mask_q  :
	                 (ptr_q == REG_IST)  ? ist     :
	                 (ptr_q == REG_OPC)  ? opc_q   : BYTE_ZERO;

	// outputs
	assign pif.out     = out_q;
	assign pif.cfg     = cfg_q;
	assign pif.od      = opc_q[OPC_OD_BIT];
	assign port_pin_o  = pif.o;
	assign port_pin_oe = pif.oe;
	assign drive_str_o = {ds1_q, ds0_q};
	assign pull_en_o   = pen_q;
	assign pull_up_o   = psel_q;
	assign sda_o       = 1'b0;
	assign sda_oe      = sda_oe_q;
	assign alert_n_o   = 1'b0;
	assign alert_n_oe  = alert_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			fresh_q <= 1'b1;
		end else if (ce) begin
			scl_q   <= scl_s;
			sda_q   <= sda_s;
			fresh_q <= 1'b0;
		end
	end

	// serial slave engine
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_q      <= ST_IDLE;
			cnt_q     <= CNT_ZERO;
			sh_q      <= BYTE_ZERO;
			ptr_q     <= REG_IN;
			addr_ph_q <= 1'b0;
			cmd_got_q <= 1'b0;
			rw_q      <= 1'b0;
			nack_q    <= 1'b0;
			sda_oe_q  <= 1'b0;
		end else if (ce) begin
			if (start_c) begin
				st_q      <= ST_RX;
				cnt_q     <= CNT_ZERO;
				addr_ph_q <= 1'b1;
				cmd_got_q <= 1'b0;
				sda_oe_q  <= 1'b0;
			end else if (stop_c) begin
				st_q     <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				unique case (st_q)
					ST_IDLE: sda_oe_q <= 1'b0;
					ST_RX: begin
						if (scl_rise) begin
							sh_q  <= {sh_q[6:0], sda_s};
							cnt_q <= cnt_q + CNT_ONE;
						end else if (byte_end) begin
							cnt_q     <= CNT_ZERO;
							addr_ph_q <= 1'b0;
							if (addr_ph_q && !addr_hit) begin
								st_q <= ST_IDLE;
							end else begin
								st_q     <= ST_ACK;
								sda_oe_q <= 1'b1;
							end
							if (addr_ph_q) rw_q <= sh_q[0];
							if (cmd_done) begin
								ptr_q     <= sh_q;
								cmd_got_q <= 1'b1;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall && rw_q) begin
							st_q     <= ST_TX;
							sh_q     <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
						end else if (scl_fall) begin
							st_q     <= ST_RX;
							sda_oe_q <= 1'b0;
						end
					end
					ST_TX: begin
						if (scl_fall && cnt_q == BIT_LAST) begin
							st_q     <= ST_RACK;
							cnt_q    <= CNT_ZERO;
							sda_oe_q <= 1'b0;
						end else if (scl_fall) begin
							sh_q     <= {sh_q[6:0], 1'b0};
							sda_oe_q <= ~sh_q[6];
							cnt_q    <= cnt_q + CNT_ONE;
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							nack_q <= sda_s;
						end else if (scl_fall && nack_q) begin
							st_q <= ST_IDLE;
						end else if (scl_fall) begin
							st_q     <= ST_TX;
							sh_q     <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// base register set
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			out_q <= RST_OUT;
			pol_q <= RST_POL;
			cfg_q <= RST_CFG;
		end else if (ce) begin
			if (wr_out) out_q <= sh_q;
			if (wr_pol) pol_q <= sh_q;
			if (wr_cfg) cfg_q <= sh_q;
		end
	end

	// extended pin features
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ds0_q  <= RST_DS;
			ds1_q  <= RST_DS;
			lat_q  <= RST_LAT;
			pen_q  <= RST_PEN;
			psel_q <= RST_PSEL;
			mask_q <= RST_MASK;
			opc_q  <= RST_OPC;
		end else if (ce) begin
			if (wr_ds0)  ds0_q  <= sh_q;
			if (wr_ds1)  ds1_q  <= sh_q;
			if (wr_lat)  lat_q  <= sh_q;
			if (wr_pen)  pen_q  <= sh_q;
			if (wr_psel) psel_q <= sh_q;
			if (wr_mask) mask_q <= sh_q;
			if (wr_opc)  opc_q  <= sh_q;
		end
	end

	// input snapshot, latch capture and alert
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			snap_q  <= BYTE_ZERO;
			hold_q  <= BYTE_ZERO;
			held_q  <= BYTE_ZERO;
			alert_q <= 1'b0;
		end else if (ce) begin
			if (in_read) begin
				snap_q <= sensed;
				hold_q <= BYTE_ZERO;
			end else begin
				hold_q <= hold_q | capture;
				held_q <= (capture & sensed) | (~capture & held_q);
			end
			alert_q <= |ist;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence addr_seen;
		ce && !start_c && !stop_c && addr_done;
	endsequence

	sequence cmd_seen;
		ce && !start_c && !stop_c && cmd_done;
	endsequence

	por_mask_a: assert property (fresh_q |-> mask_q == RST_MASK)
		else $error("mask not all set after reset");
	por_input_a: assert property (fresh_q |-> port_pin_oe == BYTE_ZERO)
		else $error("pin driven after reset");
	alert_drv_a: assert property (alert_n_oe |-> !alert_n_o)
		else $error("alert drives a high level");
	alert_cause_a: assert property (ce && (differ & ~lat_q & ~mask_q) != BYTE_ZERO |=> alert_n_oe)
		else $error("unmasked change did not raise alert");
	mask_quiet_a: assert property (ce && mask_q == RST_MASK |=> !alert_n_oe)
		else $error("alert with all pins masked");
	status_idle_a: assert property (ce && ist == BYTE_ZERO |=> !alert_n_oe)
		else $error("alert without status bit");
	latch_keep_a: assert property (ce && !in_read |=> (hold_q & $past(hold_q)) == $past(hold_q))
		else $error("latched change lost before read");
	read_clear_a: assert property (ce && in_read |=> snap_q == $past(sensed))
		else $error("input read did not refresh snapshot");
	addr_ack_a: assert property (addr_seen ##0 addr_hit |=> st_q == ST_ACK && sda_oe)
		else $error("own address not acknowledged");
	addr_miss_a: assert property (addr_seen ##0 !addr_hit |=> st_q == ST_IDLE && !sda_oe)
		else $error("foreign address acknowledged");
	rw_dir_a: assert property (st_q == ST_TX |-> rw_q)
		else $error("data sent on a write transfer");
	ptr_load_a: assert property (cmd_seen |=> ptr_q == $past(sh_q) ##1 cmd_got_q)
		else $error("command byte not stored");
endmodule : gx_top

// File: logic/gx_pkg.sv
package gx_pkg;
	// system clock and the fastest bus clock
	localparam int CLK_KHZ      = 10000;
	localparam int FSCL_MAX_KHZ = 400;
	// shortest scl half period, in core clocks
	localparam int SCL_HALF_CYC = CLK_KHZ / (2 * FSCL_MAX_KHZ);
	localparam int SYNC_STAGES  = 3;

	// upper slave address bits; straps fill the low three
	localparam logic [3:0] ADDR_BASE = 4'h4;

	// command byte values
	localparam logic [7:0] REG_IN   = 8'h00;
	localparam logic [7:0] REG_OUT  = 8'h01;
	localparam logic [7:0] REG_POL  = 8'h02;
	localparam logic [7:0] REG_CFG  = 8'h03;
	localparam logic [7:0] REG_DS0  = 8'h40;
	localparam logic [7:0] REG_DS1  = 8'h41;
	localparam logic [7:0] REG_LAT  = 8'h42;
	localparam logic [7:0] REG_PEN  = 8'h43;
	localparam logic [7:0] REG_PSEL = 8'h44;
	localparam logic [7:0] REG_MASK = 8'h45;
	localparam logic [7:0] REG_IST  = 8'h46;
	localparam logic [7:0] REG_OPC  = 8'h47;

	// power-up values
	localparam logic [7:0] RST_OUT  = 8'hFF;
	localparam logic [7:0] RST_POL  = 8'h00;
	localparam logic [7:0] RST_CFG  = 8'hFF;
	localparam logic [7:0] RST_DS   = 8'hFF;
	localparam logic [7:0] RST_LAT  = 8'h00;
	localparam logic [7:0] RST_PEN  = 8'h00;
	localparam logic [7:0] RST_PSEL = 8'hFF;
	localparam logic [7:0] RST_MASK = 8'hFF;
	localparam logic [7:0] RST_OPC  = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int         OPC_OD_BIT = 0;

	// bit counter marks
	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_ZERO  = 4'h0;
	localparam logic [3:0] CNT_ONE   = 4'h1;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_RACK = 5'h10
	} gx_st_t;
endpackage : gx_pkg

// File: logic/gx_port_if.sv
`timescale 1ns/1ps
interface gx_port_if;
	logic [7:0] out;
	logic [7:0] cfg;
	logic       od;
	logic [7:0] o;
	logic [7:0] oe;
	modport ctl (output out, output cfg, output od, input o, input oe);
	modport drv (input out, input cfg, input od, output o, output oe);
endinterface : gx_port_if

// File: logic/gx_sync.sv
`timescale 1ns/1ps
module gx_sync import gx_pkg::*; #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	wire  [W-1:0] agree = ~(s2_q ^ s3_q);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			q    <= RST;
		end else if (ce) begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q    <= (agree & s3_q) | (~agree & q);
		end
	end
endmodule : gx_sync

// File: logic/gx_port.sv
`timescale 1ns/1ps
module gx_port import gx_pkg::*; (
	// clock
	input wire logic core_clk,
	input wire logic resetn,
	// pin stage controls
	gx_port_if.drv   p
);
	for (genvar i = 0; i < 8; i++) begin : g_pin
		// input when cfg set; open drain drives only a low
		assign p.oe[i] = ~p.cfg[i] & (~p.od | ~p.out[i]);
		assign p.o[i]  = p.out[i];

		cfg_dir_a: assert property (@(posedge core_clk) disable iff (!resetn)
			p.cfg[i] |-> !p.oe[i])
			else $error("pin configured as input is driven");
		od_high_a: assert property (@(posedge core_clk) disable iff (!resetn)
			(p.od && p.out[i]) |-> !p.oe[i])
			else $error("open drain pin drives a high");
	end
endmodule : gx_port

// File: tb/gx_mst.sv
`timescale 1ns/1ps
module gx_mst #(
	parameter int Q = 625
) (
	// bus lines, sda_drv low pulls the data line
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_line
);
	initial begin
		scl     = 1'h1;
		sda_drv = 1'h1;
	end

	// scl half period of 2*Q keeps the bus at or below 400 kHz
	task automatic bit_io(input logic b, output logic r);
		#Q sda_drv = b;
		#Q scl = 1'h1;
		#Q r = sda_line;
		#Q scl = 1'h0;
	endtask : bit_io

	task automatic start();
		#Q sda_drv = 1'h0;
		#Q scl = 1'h0;
	endtask : start

	task automatic stop();
		#Q sda_drv = 1'h0;
		#Q scl = 1'h1;
		#Q sda_drv = 1'h1;
		#Q;
	endtask : stop

	// msb first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] w, input logic a, output logic [7:0] r,
			output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(w[i], r[i]);
		bit_io(a, k);
	endtask : byte_io
endmodule : gx_mst

// File: tb/i2c_gpio_expander_8bit_tb_top.sv
`timescale 1ns/1ps
module i2c_gpio_expander_8bit_tb_top import gx_pkg::*; ;
	logic        core_clk = 1'h0;
	logic        resetn   = 1'h0;
	logic        ce       = 1'h1;
	logic        sda_o;
	logic [7:0]  port_pin_i;
	logic [7:0]  port_pin_o;
	logic [7:0]  port_pin_oe;
	logic [15:0] drive_str_o;
	logic [7:0]  pull_en_o;
	logic [7:0]  pull_up_o;
	logic        sda_oe;
	logic        alert_n_o;
	logic        alert_n_oe;
	wire         scl;
	wire         sda_drv;
	wire         sda_line;
	wire         alert_line;
	int          num_errors  = 0;
	int          comparisons = 0;
	int          cyc         = 0;

	// open-drain lines with pull-ups
	assign sda_line   = sda_drv && (sda_oe !== 1'h1 || sda_o === 1'h1);
	assign alert_line = (alert_n_oe !== 1'h1);

	always #50 core_clk = ~core_clk;

	gx_top u_gx_top (
		.core_clk(core_clk), .resetn(resetn), .ce(ce),
		.scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
		.addr_strap_0(1'h1), .addr_strap_1(1'h0), .addr_strap_2(1'h1),
		.port_pin_i(port_pin_i), .port_pin_o(port_pin_o), .port_pin_oe(port_pin_oe),
		.drive_str_o(drive_str_o), .pull_en_o(pull_en_o), .pull_up_o(pull_up_o),
		.alert_n_i(alert_line), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe)
	);

	gx_mst u_gx_mst (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		logic [7:0] r;
		logic       k;
		u_gx_mst.start();
		u_gx_mst.byte_io({ADDR_BASE, 3'h5, 1'h0}, 1'h1, r, k);
		check(k, 1'h0);
		u_gx_mst.byte_io(ptr, 1'h1, r, k);
		check(k, 1'h0);
		u_gx_mst.byte_io(d, 1'h1, r, k);
		check(k, 1'h0);
		u_gx_mst.stop();
	endtask : wr

	task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
		logic [7:0] r;
		logic       k;
		u_gx_mst.start();
		u_gx_mst.byte_io({ADDR_BASE, 3'h5, 1'h0}, 1'h1, r, k);
		u_gx_mst.byte_io(ptr, 1'h1, r, k);
		u_gx_mst.stop();
		u_gx_mst.start();
		u_gx_mst.byte_io({ADDR_BASE, 3'h5, 1'h1}, 1'h1, r, k);
		check(k, 1'h0);
		u_gx_mst.byte_io(8'hFF, 1'h1, r, k);
		check(r, e);
		u_gx_mst.stop();
	endtask : rd

	task automatic set_pins(input logic [7:0] v);
		@(posedge core_clk);
		#1 port_pin_i = v;
	endtask : set_pins

	task automatic wait_alert(input logic e);
		for (int i = 0; i < 20 && alert_n_oe !== e; i++)
			@(posedge core_clk) #1;
		check(alert_n_oe, e);
	endtask : wait_alert

	task automatic t_reset();
		check(port_pin_oe, 16'h0000);
		check(port_pin_o, 16'h00FF);
		check(drive_str_o, 16'hFFFF);
		check({pull_en_o, pull_up_o}, 16'h00FF);
		check(alert_n_oe, 1'h0);
		check(alert_n_o, 1'h0);
		rd(REG_MASK, 8'hFF);
		rd(REG_CFG, 8'hFF);
		rd(REG_POL, 8'h00);
		rd(REG_IST, 8'h00);
	endtask : t_reset

	task automatic t_addr();
		logic [7:0] r;
		logic       k;
		u_gx_mst.start();
		u_gx_mst.byte_io({ADDR_BASE, 3'h2, 1'h0}, 1'h1, r, k);
		u_gx_mst.stop();
		check(k, 1'h1);
		wr(REG_IST, 8'hFF);
		rd(REG_IST, 8'h00);
	endtask : t_addr

	task automatic t_dir();
		wr(REG_OUT, 8'hA5);
		wr(REG_CFG, 8'h0F);
		check(port_pin_o, 16'h00A5);
		check(port_pin_oe, 16'h00F0);
		wr(REG_OPC, 8'h01);
		check(port_pin_oe, 16'h0050);
		wr(REG_OPC, 8'h00);
		check(port_pin_oe, 16'h00F0);
		rd(REG_OUT, 8'hA5);
	endtask : t_dir

	task automatic t_pads();
		wr(REG_DS0, 8'h1B);
		wr(REG_DS1, 8'hE4);
		check(drive_str_o, 16'hE41B);
		wr(REG_PEN, 8'h3C);
		wr(REG_PSEL, 8'h0F);
		check({pull_en_o, pull_up_o}, 16'h3C0F);
		rd(REG_DS0, 8'h1B);
		rd(REG_PSEL, 8'h0F);
	endtask : t_pads

	task automatic t_alert();
		set_pins(8'h5A);
		wr(REG_POL, 8'h0F);
		rd(REG_IN, 8'h55);
		check(alert_n_oe, 1'h0);
		wr(REG_MASK, 8'hFE);
		set_pins(8'h5B);
		wait_alert(1'h1);
		rd(REG_IST, 8'h01);
		rd(REG_IN, 8'h54);
		wait_alert(1'h0);
		set_pins(8'h5A);
		wait_alert(1'h1);
		set_pins(8'h5B);
		wait_alert(1'h0);
		set_pins(8'h7B);
		repeat (20) @(posedge core_clk);
		check(alert_n_oe, 1'h0);
	endtask : t_alert

	task automatic t_latch();
		wr(REG_LAT, 8'h02);
		wr(REG_MASK, 8'hFC);
		rd(REG_IN, 8'h74);
		set_pins(8'h79);
		repeat (10) @(posedge core_clk);
		set_pins(8'h7B);
		repeat (20) @(posedge core_clk);
		check(alert_n_oe, 1'h1);
		rd(REG_IN, 8'h76);
		wait_alert(1'h0);
	endtask : t_latch

	// clock enable low must freeze pin sensing and the alert
	task automatic t_ce();
		@(posedge core_clk);
		#1 ce = 1'h0;
		set_pins(8'h7A);
		repeat (20) @(posedge core_clk);
		check(alert_n_oe, 1'h0);
		#1 ce = 1'h1;
		wait_alert(1'h1);
		rd(REG_IN, 8'h75);
		wait_alert(1'h0);
	endtask : t_ce

	initial begin
		port_pin_i = 8'h00;
		repeat (2) @(posedge core_clk);
		#1 resetn = 1'h1;
		repeat (4) @(posedge core_clk);
		t_reset();
		t_addr();
		t_dir();
		t_pads();
		t_alert();
		t_latch();
		t_ce();
		finish_test();
	end
endmodule : i2c_gpio_expander_8bit_tb_top
